// ---- bench/fsec_core_model.sv ----
// Flash array core stand-in: array data from the address, done pulse after a program or bulk erase
`timescale 1ns/100ps
`default_nettype none
module fsec_core_model (
  // Clock and reset
  input wire logic         clk,
  input wire logic         rst_n,
  // Address and requests
  input wire logic [15:0]  bus_addr,
  input wire logic         core_prog,
  input wire logic         core_bulk,
  // Answers
  output logic [7:0]       array_rdata,
  output logic             core_done
);
  logic [2:0] cnt_q;
  // Data depends on the address so a stale or misrouted read shows up
  assign array_rdata = bus_addr[7:0] ^ 8'h5a;
  always_ff @(posedge clk) begin
    core_done <= rst_n && (cnt_q == 3'h1);
    cnt_q     <= !rst_n ? 3'h0 : (core_prog | core_bulk) ? 3'h4 : (cnt_q != 3'h0) ? cnt_q - 3'h1 : 3'h0;
  end
endmodule : fsec_core_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the flash sector erase sequencer
`timescale 1ns/100ps
`default_nettype none
`include "fsec_defs.svh"
module tb_top;
  logic clk = 0, rst_n = 0, ext_reset_n = 1, wdog_timeout = 0, low_vcc_detect = 0, debug_reset = 0;
  logic bus_wr = 0, bus_rd = 0, csiop_select = 0, security_set = 0, supply_lockout = 0;
  logic dbg_rdwr_req = 0, dbg_erase_req = 0;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0] bus_wdata = 8'h00, main_sector_select = 8'h00, main_protect = 8'h00, v, a;
  logic [3:0] secondary_protect = 4'h0;
  wire logic [7:0] bus_rdata, array_rdata, core_wdata, core_erase_sector, invalid_sectors;
  wire logic [15:0] core_addr;
  wire logic dbg_rdwr_grant, dbg_erase_grant, core_done, core_prog, core_bulk, core_erase_active, core_erase_secondary;
  int miscompares = 0, checks_done = 0, progs = 0, bulks = 0, n;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (core_prog === 1'b1) progs++;
  always @(posedge clk) if (core_bulk === 1'b1) bulks++;
  fsec_ctrl #(.ERASE_CYCLES(24'h0007d0)) fsec_ctrl_i (.clk(clk), .rst_n(rst_n), .ext_reset_n(ext_reset_n),
    .wdog_timeout(wdog_timeout), .low_vcc_detect(low_vcc_detect), .debug_reset(debug_reset), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .csiop_select(csiop_select), .main_sector_select(main_sector_select), .secondary_sector_select(4'h0),
    .main_protect(main_protect), .secondary_protect(secondary_protect), .security_set(security_set),
    .supply_lockout(supply_lockout), .dbg_rdwr_req(dbg_rdwr_req), .dbg_erase_req(dbg_erase_req),
    .dbg_rdwr_grant(dbg_rdwr_grant), .dbg_erase_grant(dbg_erase_grant), .array_rdata(array_rdata),
    .core_done(core_done), .core_fail(1'b0), .core_prog(core_prog), .core_bulk(core_bulk),
    .core_addr(core_addr), .core_wdata(core_wdata), .core_erase_active(core_erase_active),
    .core_erase_sector(core_erase_sector), .core_erase_secondary(core_erase_secondary),
    .invalid_sectors(invalid_sectors));
  fsec_core_model fsec_core_model_i (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .core_prog(core_prog),
    .core_bulk(core_bulk), .array_rdata(array_rdata), .core_done(core_done));
  task report_and_stop;
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wr(input logic [7:0] sel, input logic [7:0] d);
    @(posedge clk) #2;
    bus_wr = 1;
    bus_addr = {8'h10, sel};
    main_sector_select = sel;
    bus_wdata = d;
    @(posedge clk) #2;
    bus_wr = 0;
    main_sector_select = 8'h00;
  endtask : wr
  task rd(input logic [7:0] sel, input logic cs);
    @(posedge clk) #2;
    bus_rd = 1;
    csiop_select = cs;
    bus_addr = {cs ? 8'h00 : 8'h10, sel};
    main_sector_select = cs ? 8'h00 : sel;
    @(posedge clk) #2;
    bus_rd = 0;
    csiop_select = 0;
    main_sector_select = 8'h00;
    v = bus_rdata;
  endtask : rd
  // Host always opens with the two unlock bytes and keeps appends in one array
  task cmd6(input logic [7:0] sel, input logic [7:0] c3, input logic [7:0] c6);
    wr(sel, `FSEC_CMD_UNLOCK1);
    wr(sel, `FSEC_CMD_UNLOCK2);
    wr(sel, c3);
    if (c3 == `FSEC_CMD_ESETUP) begin
      wr(sel, `FSEC_CMD_UNLOCK1);
      wr(sel, `FSEC_CMD_UNLOCK2);
    end
    wr(sel, c6);
  endtask : cmd6
  task wait_act(input logic lvl);
    for (n = 0; n < 100 && core_erase_active !== lvl; n++) @(posedge clk);
    if (n == 100) begin
      miscompares++;
      report_and_stop();
    end
  endtask : wait_act
  task t_regs;
    main_protect = 8'h81;
    secondary_protect = 4'h5;
    {security_set, dbg_rdwr_req, dbg_erase_req} = 3'b111;
    rd(8'hc0, 1); chk("main_prot", v, 8'h81);
    rd(8'hc2, 1); chk("sec_prot", v, 8'h85);
    rd(8'hc4, 1); chk("unmapped", v, 8'h00);
    chk("rdwr_grant", {7'h0, dbg_rdwr_grant}, 8'h00);
    chk("erase_grant", {7'h0, dbg_erase_grant}, 8'h01);
    {security_set, dbg_rdwr_req, dbg_erase_req} = 3'b000;
  endtask : t_regs
  task t_prog;
    // Only main sector 7 protected, so the lockout case is refused by lockout alone
    main_protect = 8'h80;
    supply_lockout = 1;
    cmd6(8'h01, `FSEC_CMD_PROG, 8'h3c);
    supply_lockout = 0;
    cmd6(8'h80, `FSEC_CMD_PROG, 8'h3c);
    repeat (8) @(posedge clk);
    chk("refused_progs", progs[7:0], 8'h00);
    rd(8'h80, 0); chk("prot_read", v, 8'hda);
    cmd6(8'h01, `FSEC_CMD_PROG, 8'h3c);
    repeat (8) @(posedge clk);
    chk("progs", progs[7:0], 8'h01);
    chk("core_wdata", core_wdata, 8'h3c);
    chk("core_addr", core_addr[7:0], 8'h01);
    #2 main_protect = 8'h00;
    cmd6(8'h01, `FSEC_CMD_ESETUP, `FSEC_CMD_BULK);
    wr(8'h01, `FSEC_CMD_RESET);
    repeat (8) @(posedge clk);
    chk("bulks", bulks[7:0], 8'h01);
    rd(8'h01, 0); chk("bulk_reset", v, 8'h5b);
  endtask : t_prog
  task t_erase;
    cmd6(8'h02, `FSEC_CMD_ESETUP, `FSEC_CMD_SECTOR);
    rd(8'h02, 0); chk("window_open", {7'h0, v[`FSEC_BIT_WINDOW]}, 8'h00);
    wr(8'h04, `FSEC_CMD_SECTOR);
    repeat (3210) @(posedge clk);
    chk("erasing", {7'h0, core_erase_active}, 8'h01);
    chk("first_sector", core_erase_sector, 8'h02);
    chk("erase_arr", {7'h0, core_erase_secondary}, 8'h00);
    rd(8'h02, 0);
    a = v;
    rd(8'h02, 0); chk("toggle", {7'h0, a[6] ^ v[6]}, 8'h01);
    chk("status", v & 8'hbf, 8'h08);
    cmd6(8'h01, `FSEC_CMD_PROG, 8'h12);
    repeat (8) @(posedge clk);
    chk("prog_in_erase", progs[7:0], 8'h01);
    wr(8'h02, `FSEC_CMD_SUSPEND);
    repeat (610) @(posedge clk);
    chk("suspended", {7'h0, core_erase_active}, 8'h00);
    rd(8'h02, 0); chk("erasing_read", v, `FSEC_INVALID_BYTE);
    rd(8'h01, 0); chk("other_read", v, 8'h5b);
    cmd6(8'h01, `FSEC_CMD_PROG, 8'h12);
    repeat (8) @(posedge clk);
    chk("prog_in_susp", progs[7:0], 8'h01);
    wr(8'h02, `FSEC_CMD_SECTOR);
    wait_act(1'b1);
    wr(8'h02, `FSEC_CMD_RESET);
    repeat (1010) @(posedge clk);
    chk("invalid", invalid_sectors, 8'h06);
    rd(8'h02, 0); chk("read_mode", v, 8'h58);
  endtask : t_erase
  task t_sysrst;
    for (int i = 0; i < 4; i++) begin
      cmd6(8'h08, `FSEC_CMD_ESETUP, `FSEC_CMD_SECTOR);
      {ext_reset_n, wdog_timeout, low_vcc_detect, debug_reset} = 4'b1000 ^ (4'b1000 >> i);
      @(posedge clk) #2;
      {ext_reset_n, wdog_timeout, low_vcc_detect, debug_reset} = 4'b1000;
      rd(8'h08, 0); chk("sys_reset", v, 8'h52);
    end
  endtask : t_sysrst
  initial begin
    repeat (16) @(posedge clk);
    #2 rst_n = 1;
    t_regs();
    t_prog();
    t_erase();
    t_sysrst();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire

// ---- include/fsec_defs.svh ----
// Constants for the flash sector erase sequencer
`ifndef FSEC_DEFS_SVH
`define FSEC_DEFS_SVH
// ****************************************
// Command bytes
// ****************************************
`define FSEC_CMD_UNLOCK1 8'haa
`define FSEC_CMD_UNLOCK2 8'h55
`define FSEC_CMD_PROG    8'ha0
`define FSEC_CMD_ESETUP  8'h80
`define FSEC_CMD_SECTOR  8'h30
`define FSEC_CMD_BULK    8'h10
`define FSEC_CMD_SUSPEND 8'hb0
`define FSEC_CMD_RESET   8'hf0
// ****************************************
// Registers and status bit positions
// ****************************************
`define FSEC_OFS_MAIN_PROT 8'hc0
`define FSEC_OFS_SEC_PROT  8'hc2
`define FSEC_BIT_POLL      7
`define FSEC_BIT_TOGGLE    6
`define FSEC_BIT_ERROR     5
`define FSEC_BIT_WINDOW    3
`define FSEC_BIT_SECURE    7
`define FSEC_INVALID_BYTE  8'hff
`define FSEC_RDATA_RESET   8'h00
// ****************************************
// Timing (times in us, counts at the clock rate)
// ****************************************
`define FSEC_CLK_MHZ  40
`define FSEC_WIN_US   80
`define FSEC_SUSP_US  15
`define FSEC_RST_US   25
`define FSEC_WIN_CYC  (`FSEC_WIN_US * `FSEC_CLK_MHZ)
`define FSEC_SUSP_CYC (`FSEC_SUSP_US * `FSEC_CLK_MHZ)
`define FSEC_RST_CYC  (`FSEC_RST_US * `FSEC_CLK_MHZ)
`endif

// ---- include/fsec_ifs.sv ----
// Interfaces between the sequencer, its command decoder and its timers
`timescale 1ns/100ps
`default_nettype none
interface fsec_tmr_if #(parameter int W = 16);
  logic         load;
  logic [W-1:0] val;
  logic         run;
  logic         expired;
  modport owner (output load, output val, output run, input expired);
  modport timer (input load, input val, input run, output expired);
endinterface : fsec_tmr_if

interface fsec_cmd_if;
  logic cmd_reset;
  logic cmd_prog;
  logic cmd_sect;
  logic cmd_bulk;
  logic cmd_single30;
  logic cmd_suspend;
  modport dec (output cmd_reset, output cmd_prog, output cmd_sect, output cmd_bulk,
               output cmd_single30, output cmd_suspend);
  modport seq (input cmd_reset, input cmd_prog, input cmd_sect, input cmd_bulk,
               input cmd_single30, input cmd_suspend);
endinterface : fsec_cmd_if
`default_nettype wire

// ---- include/fsec_pkg.sv ----
// Types shared by the flash sector erase sequencer
package fsec_pkg;
  typedef enum logic [3:0] {
    FS_IDLE, FS_PROG, FS_BULK, FS_WIN, FS_ERASE, FS_SUSP_WAIT, FS_SUSP, FS_ABORT, FS_FAULT
  } fsec_state_t;
  typedef enum logic [2:0] {
    DEC_IDLE, DEC_U1, DEC_U2, DEC_PROG, DEC_ES, DEC_EU1, DEC_EU2
  } fsec_dec_t;
endpackage : fsec_pkg

// ---- src/fsec_cmd_dec.sv ----
// Bus write cycle decoder for unlock and command sequences
`timescale 1ns/100ps
`default_nettype none
`include "fsec_defs.svh"
module fsec_cmd_dec (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Bus write cycle
  input wire logic        bus_wr,
  input wire logic [7:0]  bus_wdata,
  // Decoded commands
  fsec_cmd_if.dec         cmd
);
  import fsec_pkg::*;
  fsec_dec_t step_q;
  fsec_dec_t step_d;

  always_comb begin
    step_d           = step_q;
    cmd.cmd_reset    = 1'b0;
    cmd.cmd_prog     = 1'b0;
    cmd.cmd_sect     = 1'b0;
    cmd.cmd_bulk     = 1'b0;
    cmd.cmd_single30 = 1'b0;
    cmd.cmd_suspend  = 1'b0;
    if (bus_wr) begin
      step_d = DEC_IDLE;
      // The program data byte may hold any value, so it is never taken as a command
      if (step_q == DEC_PROG) begin
        cmd.cmd_prog = 1'b1;
      end else if (bus_wdata == `FSEC_CMD_RESET) begin
        cmd.cmd_reset = 1'b1; // R14
      end else begin
        // A wrong byte anywhere drops the sequence back to the start
        case (step_q)
          DEC_IDLE: begin
            if (bus_wdata == `FSEC_CMD_UNLOCK1) begin
              step_d = DEC_U1;
            end
            cmd.cmd_single30 = (bus_wdata == `FSEC_CMD_SECTOR);
            cmd.cmd_suspend  = (bus_wdata == `FSEC_CMD_SUSPEND);
          end
          DEC_U1:  if (bus_wdata == `FSEC_CMD_UNLOCK2) step_d = DEC_U2;
          DEC_U2: begin
            if (bus_wdata == `FSEC_CMD_PROG) begin
              step_d = DEC_PROG;
            end else if (bus_wdata == `FSEC_CMD_ESETUP) begin
              step_d = DEC_ES;
            end
          end
          DEC_ES:  if (bus_wdata == `FSEC_CMD_UNLOCK1) step_d = DEC_EU1;
          DEC_EU1: if (bus_wdata == `FSEC_CMD_UNLOCK2) step_d = DEC_EU2;
          DEC_EU2: begin
            cmd.cmd_sect = (bus_wdata == `FSEC_CMD_SECTOR); // R1
            cmd.cmd_bulk = (bus_wdata == `FSEC_CMD_BULK);
          end
          default: step_d = DEC_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      step_q <= DEC_IDLE;
    end else begin
      step_q <= step_d;
    end
  end
endmodule : fsec_cmd_dec
`default_nettype wire

// ---- src/fsec_ctrl.sv ----
// Flash sector erase sequencer with protection and security status
// How it works
// (R1) Sector erase needs six correct writes before erasing starts.
// (R2) A bare 30h to another sector inside 80us appends that sector.
// (R3) Window flag reads 0 while the append window is open, 1 after.
// (R4) Host appends nothing once the window flag is 1.
// (R5) Array reads during erase return error, toggle and polling status.
// (R6) During erase only reset and suspend commands are obeyed.
// (R7) Host addresses appended sectors in the same array.
// (R8) B0h suspends, only while an erase runs.
// (R9) Suspend reaches read-array mode within 15us.
// (R10) While suspended, erasing sectors read invalid, others read array data.
// (R11) While suspended, programming is refused; only resume and reset obeyed.
// (R12) Reset while suspended ends the erase and marks its sectors invalid.
// (R13) 30h while suspended resumes where the erase stopped.
// (R14) Reset is one write and returns the array to read mode.
// (R15) Reset ignored in program or bulk erase; aborts sector erase within 25us.
// (R16) System reset aborts any operation and restores read mode.
// (R17) System reset comes from reset pin, watchdog, low supply or debug.
// (R18) Writes to protected sectors are ignored; reads still work.
// (R19) Register C0h shows main sector protection, read only.
// (R20) Register C2h shows secondary protection and security bit 7.
// (R21) Security blocks debug flash access except full erase.
// (R22) Writes are inhibited while supply lockout is active.
// (R23) Commands other than reset start with AAh then 55h; suspend B0h and the append or resume 30h are taken bare.
// (R24) Toggle flag flips on every status read while busy.
// (R25) Error flag reads 1 after an erase time-out.
// (R26) Erase time and window are parameterised cycle counts.
`timescale 1ns/100ps
`default_nettype none
`include "fsec_defs.svh"
module fsec_ctrl #(
  parameter int          ERASE_W      = 24,
  parameter logic [23:0] ERASE_CYCLES = 24'h009c40
) (
  // Clock and reset
  input wire logic         clk,
  input wire logic         rst_n,
  // System reset sources
  input wire logic         ext_reset_n,
  input wire logic         wdog_timeout,
  input wire logic         low_vcc_detect,
  input wire logic         debug_reset,
  // Processor bus
  input wire logic         bus_wr,
  input wire logic         bus_rd,
  input wire logic [15:0]  bus_addr,
  input wire logic [7:0]   bus_wdata,
  output logic [7:0]       bus_rdata,
  input wire logic         csiop_select,
  input wire logic [7:0]   main_sector_select,
  input wire logic [3:0]   secondary_sector_select,
  // Protection and supply
  input wire logic [7:0]   main_protect,
  input wire logic [3:0]   secondary_protect,
  input wire logic         security_set,
  input wire logic         supply_lockout,
  // Debug port access
  input wire logic         dbg_rdwr_req,
  input wire logic         dbg_erase_req,
  output logic             dbg_rdwr_grant,
  output logic             dbg_erase_grant,
  // Flash array core
  input wire logic [7:0]   array_rdata,
  input wire logic         core_done,
  input wire logic         core_fail,
  output logic             core_prog,
  output logic             core_bulk,
  output logic [15:0]      core_addr,
  output logic [7:0]       core_wdata,
  output logic             core_erase_active,
  output logic [7:0]       core_erase_sector,
  output logic             core_erase_secondary,
  output logic [7:0]       invalid_sectors
);
  import fsec_pkg::*;

  // ****************************************
  // Decoder and timers
  // ****************************************
  fsec_cmd_if                  cmd ();
  fsec_tmr_if #(.W(16))        win ();
  fsec_tmr_if #(.W(ERASE_W))   op ();

  fsec_cmd_dec u_dec (.clk(clk), .rst_n(rst_n), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .cmd(cmd));
  fsec_timer #(.W(16))      u_win (.clk(clk), .rst_n(rst_n), .tmr(win));
  fsec_timer #(.W(ERASE_W)) u_op  (.clk(clk), .rst_n(rst_n), .tmr(op));

  // ****************************************
  // Address and protection terms
  // ****************************************
  logic       sys_reset;
  logic       sel_sec;
  logic       sel_hit;
  logic [7:0] sel_vec;
  logic       prot_hit;
  logic       wr_ok;
  logic       same_arr;
  logic [7:0] cur_sect;

  assign sys_reset = !ext_reset_n || wdog_timeout || low_vcc_detect || debug_reset; // R17
  assign sel_sec   = |secondary_sector_select;
  assign sel_hit   = sel_sec || (|main_sector_select);
  assign sel_vec   = sel_sec ? {4'h0, secondary_sector_select} : main_sector_select;
  assign prot_hit  = |(main_sector_select & main_protect) || |(secondary_sector_select & secondary_protect);
  assign wr_ok     = sel_hit && !prot_hit && !supply_lockout; // R18 R22

  fsec_state_t st_q;
  fsec_state_t st_d;
  logic       sec_q;
  logic       sec_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic       err_q;
  logic       err_d;
  logic       tog_q;
  logic       tog_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       prog_q;
  logic       prog_d;
  logic       bulk_q;
  logic       bulk_d;
  logic [15:0] addr_q;
  logic [15:0] addr_d;
  logic [7:0] wdata_q;
  logic [7:0] wdata_d;
  logic [7:0] inv_q;
  logic [7:0] inv_d;

  assign same_arr = (sel_sec == sec_q);
  // Sectors are erased one at a time, lowest number first
  assign cur_sect = mask_q & (~mask_q + 8'h01);

  // ****************************************
  // Sequencer
  // ****************************************
  logic [7:0] status;
  logic       busy_st;
  logic       bulk_ok;

  always_comb begin
    status = 8'h00;
    status[`FSEC_BIT_POLL]   = (st_q == FS_PROG) ? ~wdata_q[7] : 1'b0;
    status[`FSEC_BIT_TOGGLE] = tog_q;                     // R24
    status[`FSEC_BIT_ERROR]  = err_q;                     // R25
    status[`FSEC_BIT_WINDOW] = (st_q != FS_WIN);          // R3
    busy_st = (st_q != FS_IDLE) && (st_q != FS_SUSP);
    bulk_ok = sel_hit && !supply_lockout &&
              !(sel_sec ? |secondary_protect : |main_protect);
  end

  always_comb begin
    st_d    = st_q;
    sec_d   = sec_q;
    mask_d  = mask_q;
    err_d   = err_q;
    tog_d   = tog_q;
    rdata_d = rdata_q;
    prog_d  = 1'b0;
    bulk_d  = 1'b0;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    inv_d   = inv_q;
    win.load = 1'b0;
    win.val  = 16'h0000;
    op.load  = 1'b0;
    op.val   = ERASE_CYCLES[ERASE_W-1:0];
    if (sys_reset) begin
      st_d   = FS_IDLE; // R16
      mask_d = 8'h00;
    end else begin
      case (st_q)
        FS_IDLE: begin
          if (cmd.cmd_prog && wr_ok) begin
            st_d    = FS_PROG;
            prog_d  = 1'b1;
            addr_d  = bus_addr;
            wdata_d = bus_wdata;
            err_d   = 1'b0;
          end else if (cmd.cmd_bulk && bulk_ok) begin
            st_d   = FS_BULK;
            bulk_d = 1'b1;
            addr_d = bus_addr;
            err_d  = 1'b0;
          end else if (cmd.cmd_sect && wr_ok) begin
            st_d     = FS_WIN; // R1
            sec_d    = sel_sec;
            mask_d   = sel_vec;
            err_d    = 1'b0;
            inv_d    = inv_q & ~sel_vec;
            win.load = 1'b1;
            win.val  = 16'(`FSEC_WIN_CYC); // R26
          end
        end
        FS_PROG, FS_BULK: begin
          // Reset is not obeyed here; a failure waits for it instead
          if (core_fail) begin // R15
            st_d  = FS_FAULT;
            err_d = 1'b1;
          end else if (core_done) begin
            st_d = FS_IDLE;
          end
        end
        FS_WIN: begin
          if (cmd.cmd_reset) begin
            st_d     = FS_ABORT;
            win.load = 1'b1;
            win.val  = 16'(`FSEC_RST_CYC);
          end else if (cmd.cmd_single30 && wr_ok && same_arr) begin
            mask_d   = mask_q | sel_vec; // R2
            win.load = 1'b1;
            win.val  = 16'(`FSEC_WIN_CYC);
          end else if (win.expired) begin
            st_d    = FS_ERASE;
            op.load = 1'b1;
          end
        end
        FS_ERASE: begin
          if (core_fail) begin
            st_d  = FS_FAULT; // R25
            err_d = 1'b1;
          end else if (cmd.cmd_reset) begin
            st_d     = FS_ABORT; // R6 R15
            inv_d    = mask_q;
            win.load = 1'b1;
            win.val  = 16'(`FSEC_RST_CYC);
          end else if (cmd.cmd_suspend && sel_hit && same_arr) begin
            st_d     = FS_SUSP_WAIT; // R8
            win.load = 1'b1;
            win.val  = 16'(`FSEC_SUSP_CYC);
          end else if (op.expired) begin
            mask_d = mask_q & ~cur_sect;
            if (mask_d == 8'h00) begin
              st_d = FS_IDLE;
            end else begin
              op.load = 1'b1; // R26
            end
          end
        end
        FS_SUSP_WAIT: begin
          if (win.expired) begin
            st_d = FS_SUSP; // R9
          end
        end
        FS_SUSP: begin
          if (cmd.cmd_reset) begin
            st_d     = FS_ABORT; // R12
            inv_d    = mask_q;
            win.load = 1'b1;
            win.val  = 16'(`FSEC_RST_CYC);
          end else if (cmd.cmd_single30 && sel_hit && same_arr) begin
            st_d = FS_ERASE; // R11 R13
          end
        end
        FS_ABORT: begin
          mask_d = 8'h00;
          if (win.expired) begin
            st_d = FS_IDLE; // R14
          end
        end
        FS_FAULT: begin
          if (cmd.cmd_reset) begin
            st_d     = FS_ABORT;
            win.load = 1'b1;
            win.val  = 16'(`FSEC_RST_CYC);
          end
        end
        default: st_d = FS_IDLE;
      endcase
    end
    // Read path; registers answer in any state
    if (bus_rd && csiop_select) begin
      if (bus_addr[7:0] == `FSEC_OFS_MAIN_PROT) begin
        rdata_d = main_protect; // R19
      end else if (bus_addr[7:0] == `FSEC_OFS_SEC_PROT) begin
        rdata_d = {security_set, 3'b000, secondary_protect}; // R20
      end else begin
        rdata_d = 8'h00;
      end
    end else if (bus_rd && sel_hit) begin
      if (busy_st) begin
        rdata_d = status; // R5
        tog_d   = ~tog_q; // R24
      end else if (st_q == FS_SUSP && same_arr && |(sel_vec & mask_q)) begin
        rdata_d = `FSEC_INVALID_BYTE; // R10
      end else begin
        rdata_d = array_rdata; // R18
      end
    end
  end

  // Op timer only counts while erasing, so a resume carries on from where it stopped
  assign win.run = 1'b1;
  assign op.run  = (st_q == FS_ERASE); // R13

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q    <= FS_IDLE;
      sec_q   <= 1'b0;
      mask_q  <= 8'h00;
      err_q   <= 1'b0;
      tog_q   <= 1'b0;
      rdata_q <= `FSEC_RDATA_RESET;
      prog_q  <= 1'b0;
      bulk_q  <= 1'b0;
      addr_q  <= 16'h0000;
      wdata_q <= 8'h00;
      inv_q   <= 8'h00;
    end else begin
      st_q    <= st_d;
      sec_q   <= sec_d;
      mask_q  <= mask_d;
      err_q   <= err_d;
      tog_q   <= tog_d;
      rdata_q <= rdata_d;
      prog_q  <= prog_d;
      bulk_q  <= bulk_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      inv_q   <= inv_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bus_rdata            = rdata_q;
  assign core_prog            = prog_q;
  assign core_bulk            = bulk_q;
  assign core_addr            = addr_q;
  assign core_wdata           = wdata_q;
  assign core_erase_active    = (st_q == FS_ERASE);
  assign core_erase_sector    = (st_q == FS_ERASE) ? cur_sect : 8'h00;
  assign core_erase_secondary = sec_q;
  assign invalid_sectors      = inv_q;
  assign dbg_rdwr_grant       = dbg_rdwr_req && !security_set; // R21
  assign dbg_erase_grant      = dbg_erase_req;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || sys_reset);

  localparam int SUSP_MAX = `FSEC_SUSP_CYC + 1;
  localparam int RST_MAX  = `FSEC_RST_CYC + 1;

  sequence s_sect_taken;
    st_q == FS_IDLE && cmd.cmd_sect && wr_ok;
  endsequence
  sequence s_susp_taken;
    st_q == FS_ERASE && !core_fail && !cmd.cmd_reset && cmd.cmd_suspend && sel_hit && same_arr;
  endsequence
  sequence s_reset_in_erase;
    st_q == FS_ERASE && !core_fail && cmd.cmd_reset;
  endsequence

  a_sect_opens_win: assert property (s_sect_taken |=> st_q == FS_WIN && mask_q != 8'h00) // R1
    else $error("sector erase did not open the window");
  a_win_flag_zero: assert property (st_q == FS_WIN && bus_rd && sel_hit && !csiop_select
                                    |=> !bus_rdata[`FSEC_BIT_WINDOW]) // R3
    else $error("window flag not zero inside window");
  a_erase_status: assert property (st_q == FS_ERASE && bus_rd && sel_hit && !csiop_select
                                   |=> !bus_rdata[`FSEC_BIT_POLL] && bus_rdata[`FSEC_BIT_WINDOW]) // R5
    else $error("erase read did not return status");
  a_erase_no_prog: assert property (st_q != FS_IDLE |=> !core_prog && !core_bulk) // R6 R11
    else $error("program started while busy");
  a_susp_latency: assert property (s_susp_taken |-> ##[1:SUSP_MAX] st_q == FS_SUSP) // R9
    else $error("suspend did not settle in time");
  a_reset_latency: assert property (s_reset_in_erase |-> ##[1:RST_MAX] st_q == FS_IDLE) // R15
    else $error("reset did not restore read mode in time");
  a_prog_keeps_reset: assert property (st_q == FS_PROG && cmd.cmd_reset && !core_fail && !core_done
                                       |=> st_q == FS_PROG) // R15
    else $error("reset obeyed during program");
  a_protect_ignore: assert property (st_q == FS_IDLE && (prot_hit || supply_lockout)
                                     |=> !core_prog && st_q != FS_WIN) // R18 R22
    else $error("write to protected sector accepted");
  a_toggle_flip: assert property (busy_st && bus_rd && sel_hit && !csiop_select
                                  |=> tog_q != $past(tog_q)) // R24
    else $error("toggle flag did not flip");
  a_secure_block: assert property (security_set |-> !dbg_rdwr_grant) // R21
    else $error("debug access granted while secured");
  a_sysrst_abort: assert property (@(posedge clk) disable iff (!rst_n) sys_reset |=> st_q == FS_IDLE
                                   && !core_erase_active) // R16
    else $error("system reset did not abort");
endmodule : fsec_ctrl
`default_nettype wire

// ---- src/fsec_timer.sv ----
// Loadable down counter that pauses while run is low
`timescale 1ns/100ps
`default_nettype none
module fsec_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic   clk,
  input wire logic   rst_n,
  // Control
  fsec_tmr_if.timer  tmr
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Expiry is seen in the last counted cycle, so a load of N gives N cycles
  assign tmr.expired = tmr.run && (cnt_q == W'(1));

  always_comb begin
    cnt_d = cnt_q;
    if (tmr.load) begin
      cnt_d = tmr.val;
    end else if (tmr.run && cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : fsec_timer
`default_nettype wire
